// File: design/pfm3_pkg.sv
// package: register map, field positions and routing codes for the pin function mux bank three
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
package pfm3_pkg;
   localparam logic [15:0] PFM3_ADDR_SEL1 = 16'h7F3D;
   localparam logic [15:0] PFM3_ADDR_SEL2 = 16'h7F40;
   localparam logic [15:0] PFM3_ADDR_SEL3 = 16'h7F30;
   localparam logic [15:0] PFM3_ADDR_DIR_LO = 16'h7F18;
   localparam logic [15:0] PFM3_ADDR_DIR_HI = 16'h7F1B;
   localparam logic [7:0] PFM3_RESET_SEL = 8'h00;
   localparam logic [7:0] PFM3_RESET_DIR = 8'h00;
   // register 3 field positions
   localparam int PFM3_B_TACH1 = 7;
   localparam int PFM3_B_KEYBOARD_RESET_OUT = 6;
   localparam int PFM3_B_TACH2 = 5;
   localparam int PFM3_B_ALLOC_HI = 4;
   localparam int PFM3_B_ALLOC_LO = 3;
   localparam int PFM3_B_SMI_PIN = 2;
   localparam int PFM3_B_SCAN13 = 1;
   // other registers
   localparam int PFM3_B_FLOPPY = 5;
   localparam int PFM3_B_SCAN_PAIR = 0;
   localparam int PFM3_B_SMI_MASK = 3;
   localparam int PFM3_B_DIR_IO4 = 4;
   localparam int PFM3_B_DIR_IO5 = 5;
   // direction bits for general I/O 11..14 in the 0x7F1B byte
   localparam int PFM3_B_DIR_IO11 = 3;
   localparam int PFM3_NUM_BUS_PINS = 4;

   typedef enum logic [1:0] {
      PFM3_ALLOC_NONE = 2'b00,
      PFM3_ALLOC_ONE_PAIR = 2'b01,
      PFM3_ALLOC_TWO_PAIRS = 2'b10,
      PFM3_ALLOC_RESERVED = 2'b11
   } pfm3_alloc_t;

   // output 5 pin function
   typedef enum logic [1:0] {
      PFM3_GENERAL_OUTPUT_5_GENERAL,
      PFM3_GENERAL_OUTPUT_5_KEYBOARD_RESET_OUT,
      PFM3_GENERAL_OUTPUT_5_FLOPPY
   } pfm3_general_output_5_t;
endpackage

// File: design/pfm3_sel_if.sv
// interface: select bits and raw select and direction bytes passed from the register file to the router
`timescale 1ns/1ps
interface pfm3_sel_if;
   logic [7:0] sel3;
   logic floppy_sel;
   logic scan_pair_sel;
   logic smi_mask;
   logic [7:0] dir_lo;
   logic [7:0] dir_hi;
   modport regs (output sel3, output floppy_sel, output scan_pair_sel, output smi_mask,
      output dir_lo, output dir_hi);
   modport route (input sel3, input floppy_sel, input scan_pair_sel, input smi_mask,
      input dir_lo, input dir_hi);
endinterface

// File: design/pfm3_regs.sv
// module: controller-side select and direction registers
`timescale 1ns/1ps
module pfm3_regs (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_wr,
   input wire logic [15:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_smi_mask,
   pfm3_sel_if.regs sel
);
   import pfm3_pkg::*;

   logic [7:0] sel1_r, sel1_nxt;
   logic [7:0] sel2_r, sel2_nxt;
   logic [7:0] sel3_r, sel3_nxt;
   logic [7:0] dlo_r, dlo_nxt;
   logic [7:0] dhi_r, dhi_nxt;

   //------------------------------------------------------------------------
   // write decode
   //------------------------------------------------------------------------
   always_comb begin
      sel1_nxt = sel1_r;
      sel2_nxt = sel2_r;
      sel3_nxt = sel3_r;
      dlo_nxt = dlo_r;
      dhi_nxt = dhi_r;
      if (i_wr && i_addr == PFM3_ADDR_SEL3) begin
         sel3_nxt = i_wdata;
      end else if (i_wr && i_addr == PFM3_ADDR_SEL1) begin
         sel1_nxt = i_wdata;
      end else if (i_wr && i_addr == PFM3_ADDR_SEL2) begin
         sel2_nxt = i_wdata;
      end else if (i_wr && i_addr == PFM3_ADDR_DIR_LO) begin
         dlo_nxt = i_wdata;
      end else if (i_wr && i_addr == PFM3_ADDR_DIR_HI) begin
         dhi_nxt = i_wdata;
      end
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         sel1_r <= PFM3_RESET_SEL;
         sel2_r <= PFM3_RESET_SEL;
         sel3_r <= PFM3_RESET_SEL;
         dlo_r <= PFM3_RESET_DIR;
         dhi_r <= PFM3_RESET_DIR;
      end else begin
         sel1_r <= sel1_nxt;
         sel2_r <= sel2_nxt;
         sel3_r <= sel3_nxt;
         dlo_r <= dlo_nxt;
         dhi_r <= dhi_nxt;
      end
   end

   // levels to the router; mask lives in the mailbox, so it is passed through
   assign sel.sel3 = sel3_r;
   assign sel.floppy_sel = sel1_r[PFM3_B_FLOPPY];
   assign sel.scan_pair_sel = sel2_r[PFM3_B_SCAN_PAIR];
   assign sel.smi_mask = i_smi_mask;
   assign sel.dir_lo = dlo_r;
   assign sel.dir_hi = dhi_r;
endmodule

// File: design/pfm3_top.sv
// module: top of pin function mux bank three, register 3 read-back and pin routing
`timescale 1ns/1ps
module pfm3_top (
   input wire logic i_clock,
   input wire logic i_rst,
   // controller register port
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [15:0] i_addr,
   input wire logic [7:0] i_wdata,
   output logic [7:0] o_rdata,
   // mailbox 97h mask bit level
   input wire logic i_smi_mask,
   // core-side sources
   input wire logic i_gpio4_out,
   input wire logic i_gpio5_out,
   input wire logic i_scan_out_14,
   input wire logic i_scan_out_15,
   input wire logic i_scan_out_13,
   input wire logic i_general_output_5,
   input wire logic i_general_output_6,
   input wire logic i_general_output_7,
   input wire logic i_keyboard_reset_out,
   input wire logic i_floppy_drive_sel_1_n,
   input wire logic i_floppy_motor_1_n,
   input wire logic i_sys_mgmt_irq_n,
   input wire logic i_general_io_18_out,
   input wire logic i_general_io_18_oe,
   input wire logic i_dma_ack_2_n,
   input wire logic [3:0] i_gpio11_14_out,
   input wire logic [3:0] i_bus2_out,
   // pad inputs
   input wire logic i_pad_gpio15,
   input wire logic i_pad_gpio16,
   input wire logic [3:0] i_pad_bus,
   // pad drives
   output logic o_pad_gpio4,
   output logic o_pad_gpio4_oe,
   output logic o_pad_gpio5,
   output logic o_pad_gpio5_oe,
   output logic o_pad_general_output_5,
   output logic o_pad_general_output_6,
   output logic o_pad_general_output_7,
   output logic o_pad_general_output_7_oe,
   output logic o_pad_scan13,
   output logic o_pad_scan13_oe,
   output logic o_pad_general_io_18,
   output logic o_pad_general_io_18_oe,
   output logic [3:0] o_pad_bus,
   output logic [3:0] o_pad_bus_oe,
   // routed inputs to core
   output logic o_fan_speed_in_1,
   output logic o_fan_speed_in_2,
   output logic o_gpio15_in,
   output logic o_gpio16_in,
   output logic [3:0] o_bus2_in,
   output logic [3:0] o_gpio11_14_in,
   // SMI path
   output logic o_serial_smi_n,
   output logic o_slot3_irq2_avail
);
   import pfm3_pkg::*;

   pfm3_sel_if sel ();

   pfm3_regs u_regs (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_wr(i_wr),
      .i_addr(i_addr),
      .i_wdata(i_wdata),
      .i_smi_mask(i_smi_mask),
      .sel(sel.regs)
   );

   // decoded fields
   logic tach1, keyboard_reset_out, tach2, smi_pin, scan13, masked;
   pfm3_alloc_t alloc;
   pfm3_general_output_5_t general_output_5_mode;
   logic [3:0] bus_use;
   logic [3:0] bus_dir;

   //------------------------------------------------------------------------
   // field decode
   //------------------------------------------------------------------------
   always_comb begin
      tach1 = sel.sel3[PFM3_B_TACH1];
      keyboard_reset_out = sel.sel3[PFM3_B_KEYBOARD_RESET_OUT];
      tach2 = sel.sel3[PFM3_B_TACH2];
      smi_pin = sel.sel3[PFM3_B_SMI_PIN];
      scan13 = sel.sel3[PFM3_B_SCAN13];
      masked = sel.smi_mask;
      alloc = pfm3_alloc_t'({sel.sel3[PFM3_B_ALLOC_HI], sel.sel3[PFM3_B_ALLOC_LO]});
      // D0 deliberately left out of every decode, reserved
   end

   //------------------------------------------------------------------------
   // output 5 and secondary bus pin decode
   //------------------------------------------------------------------------
   always_comb begin
      if (sel.floppy_sel) begin
         general_output_5_mode = PFM3_GENERAL_OUTPUT_5_FLOPPY;
      end else if (keyboard_reset_out) begin
         general_output_5_mode = PFM3_GENERAL_OUTPUT_5_KEYBOARD_RESET_OUT;
      end else begin
         general_output_5_mode = PFM3_GENERAL_OUTPUT_5_GENERAL;
      end
      // reserved allocation hands every pin back to general I/O
      case (alloc)
         PFM3_ALLOC_ONE_PAIR: bus_use = 4'b0011;
         PFM3_ALLOC_TWO_PAIRS: bus_use = 4'b1111;
         default: bus_use = 4'b0000;
      endcase
      bus_dir = sel.dir_hi[PFM3_B_DIR_IO11 -: PFM3_NUM_BUS_PINS];
   end

   // next values of every output flop
   logic [7:0] rdata_nxt;
   logic p4_nxt, p4oe_nxt, p5_nxt, p5oe_nxt, o5_nxt, o6_nxt, o7_nxt, o7oe_nxt;
   logic s13_nxt, s13oe_nxt, g18_nxt, g18oe_nxt;
   logic t1_nxt, t2_nxt, g15_nxt, g16_nxt, ssmi_nxt, irq2_nxt;
   logic [3:0] pb_nxt, pboe_nxt, b2in_nxt, gin_nxt;

   //------------------------------------------------------------------------
   // register 3 read-back decode
   //------------------------------------------------------------------------
   always_comb begin
      rdata_nxt = 8'h00;
      if (i_rd && i_addr == PFM3_ADDR_SEL3) begin
         rdata_nxt = sel.sel3;
      end
   end

   //------------------------------------------------------------------------
   // general I/O 4/5 pins
   //------------------------------------------------------------------------
   always_comb begin
      // general I/O 4/5 or scan 14/15
      if (sel.scan_pair_sel) begin
         p4_nxt = i_scan_out_14;
         p5_nxt = i_scan_out_15;
      end else begin
         p4_nxt = i_gpio4_out;
         p5_nxt = i_gpio5_out;
      end
      p4oe_nxt = sel.dir_lo[PFM3_B_DIR_IO4];
      p5oe_nxt = sel.dir_lo[PFM3_B_DIR_IO5];
   end

   //------------------------------------------------------------------------
   // general I/O 15/16 pins
   //------------------------------------------------------------------------
   always_comb begin
      // fan tach inputs
      t1_nxt = tach1 ? i_pad_gpio15 : 1'b0;
      g15_nxt = tach1 ? 1'b0 : i_pad_gpio15;
      t2_nxt = tach2 ? i_pad_gpio16 : 1'b0;
      g16_nxt = tach2 ? 1'b0 : i_pad_gpio16;
   end

   //------------------------------------------------------------------------
   // output 5 and 6 pins
   //------------------------------------------------------------------------
   always_comb begin
      // output 5 and 6
      case (general_output_5_mode)
         PFM3_GENERAL_OUTPUT_5_FLOPPY: o5_nxt = i_floppy_drive_sel_1_n;
         PFM3_GENERAL_OUTPUT_5_KEYBOARD_RESET_OUT: o5_nxt = i_keyboard_reset_out;
         default: o5_nxt = i_general_output_5;
      endcase
      o6_nxt = sel.floppy_sel ? i_floppy_motor_1_n : i_general_output_6;
   end

   //------------------------------------------------------------------------
   // output 7 pin and SMI path
   //------------------------------------------------------------------------
   always_comb begin
      // SMI: pin open-drain, or serial slot 3 when unmasked
      if (smi_pin) begin
         o7_nxt = 1'b0;
         o7oe_nxt = !masked && !i_sys_mgmt_irq_n;
      end else begin
         o7_nxt = i_general_output_7;
         o7oe_nxt = 1'b1;
      end
      ssmi_nxt = (smi_pin || masked) ? 1'b1 : i_sys_mgmt_irq_n;
      irq2_nxt = smi_pin || masked;
   end

   //------------------------------------------------------------------------
   // scan 13 and general I/O 18 pins
   //------------------------------------------------------------------------
   always_comb begin
      // scan 13 pin and general I/O 18 pin share the one bit
      if (scan13) begin
         s13_nxt = i_general_io_18_out;
         s13oe_nxt = i_general_io_18_oe;
         g18_nxt = i_dma_ack_2_n;
         g18oe_nxt = 1'b1;
      end else begin
         s13_nxt = i_scan_out_13;
         s13oe_nxt = 1'b1;
         g18_nxt = i_general_io_18_out;
         g18oe_nxt = i_general_io_18_oe;
      end
   end

   // per-pin secondary bus routing; direction bits gate the drivers
   genvar gi;
   generate
      for (gi = 0; gi < PFM3_NUM_BUS_PINS; gi++) begin : g_bus
         always_comb begin
            pb_nxt[gi] = bus_use[gi] ? i_bus2_out[gi] : i_gpio11_14_out[gi];
            pboe_nxt[gi] = bus_dir[gi];
            b2in_nxt[gi] = bus_use[gi] ? i_pad_bus[gi] : 1'b1;
            gin_nxt[gi] = bus_use[gi] ? 1'b0 : i_pad_bus[gi];
         end
      end
   endgenerate

   //------------------------------------------------------------------------
   // registered read data
   //------------------------------------------------------------------------
   // read data stands one cycle, then falls back to zero
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_rdata <= 8'h00;
      end else begin
         o_rdata <= rdata_nxt;
      end
   end

   //------------------------------------------------------------------------
   // registered output pin drives
   //------------------------------------------------------------------------
   // all outputs registered: routing follows one cycle after the write flop
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_pad_gpio4 <= 1'b0;
         o_pad_gpio4_oe <= 1'b0;
         o_pad_gpio5 <= 1'b0;
         o_pad_gpio5_oe <= 1'b0;
         o_pad_general_output_5 <= 1'b0;
         o_pad_general_output_6 <= 1'b0;
         o_pad_general_output_7 <= 1'b0;
         o_pad_general_output_7_oe <= 1'b0;
      end else begin
         o_pad_gpio4 <= p4_nxt;
         o_pad_gpio4_oe <= p4oe_nxt;
         o_pad_gpio5 <= p5_nxt;
         o_pad_gpio5_oe <= p5oe_nxt;
         o_pad_general_output_5 <= o5_nxt;
         o_pad_general_output_6 <= o6_nxt;
         o_pad_general_output_7 <= o7_nxt;
         o_pad_general_output_7_oe <= o7oe_nxt;
      end
   end

   //------------------------------------------------------------------------
   // registered shared pin drives
   //------------------------------------------------------------------------
   // drivers are released in reset; the scan 13 pin drives again from the first edge after release
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_pad_scan13 <= 1'b0;
         o_pad_scan13_oe <= 1'b0;
         o_pad_general_io_18 <= 1'b0;
         o_pad_general_io_18_oe <= 1'b0;
         o_pad_bus <= 4'h0;
         o_pad_bus_oe <= 4'h0;
      end else begin
         o_pad_scan13 <= s13_nxt;
         o_pad_scan13_oe <= s13oe_nxt;
         o_pad_general_io_18 <= g18_nxt;
         o_pad_general_io_18_oe <= g18oe_nxt;
         o_pad_bus <= pb_nxt;
         o_pad_bus_oe <= pboe_nxt;
      end
   end

   //------------------------------------------------------------------------
   // registered inputs handed to the core
   //------------------------------------------------------------------------
   // bus inputs idle high so the bus controller sees released lines
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_fan_speed_in_1 <= 1'b0;
         o_fan_speed_in_2 <= 1'b0;
         o_gpio15_in <= 1'b0;
         o_gpio16_in <= 1'b0;
         o_bus2_in <= 4'hF;
         o_gpio11_14_in <= 4'h0;
      end else begin
         o_fan_speed_in_1 <= t1_nxt;
         o_fan_speed_in_2 <= t2_nxt;
         o_gpio15_in <= g15_nxt;
         o_gpio16_in <= g16_nxt;
         o_bus2_in <= b2in_nxt;
         o_gpio11_14_in <= gin_nxt;
      end
   end

   //------------------------------------------------------------------------
   // registered serial slot 3 state
   //------------------------------------------------------------------------
   // serial SMI idles inactive so reset never reports a false SMI
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_serial_smi_n <= 1'b1;
         o_slot3_irq2_avail <= 1'b0;
      end else begin
         o_serial_smi_n <= ssmi_nxt;
         o_slot3_irq2_avail <= irq2_nxt;
      end
   end
endmodule

// File: verif/pfm3_checker.sv
// checker: port-level assertions for pin function mux bank three
`timescale 1ns/1ps
module pfm3_checker (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [15:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic [7:0] o_rdata,
   input wire logic i_smi_mask,
   input wire logic i_gpio4_out,
   input wire logic i_scan_out_14,
   input wire logic o_pad_gpio4,
   input wire logic i_pad_gpio15,
   input wire logic i_pad_gpio16,
   input wire logic o_fan_speed_in_1,
   input wire logic o_fan_speed_in_2,
   input wire logic i_general_output_5,
   input wire logic i_keyboard_reset_out,
   input wire logic i_floppy_drive_sel_1_n,
   input wire logic o_pad_general_output_5,
   input wire logic [3:0] i_pad_bus,
   input wire logic [3:0] o_bus2_in,
   input wire logic [3:0] o_pad_bus_oe,
   input wire logic i_sys_mgmt_irq_n,
   input wire logic o_serial_smi_n,
   input wire logic o_slot3_irq2_avail,
   input wire logic o_pad_general_output_7,
   input wire logic o_pad_general_output_7_oe
);
   logic [7:0] s3_r;
   logic [3:0] dh_r;
   logic fl_r;
   logic pr_r;
   logic armed_r;
   //----------------------------------------
   // select shadows
   //----------------------------------------
   // shadows of written selects, so pin checks need no internal probes
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         s3_r <= 8'h00;
         dh_r <= 4'h0;
         fl_r <= 1'b0;
         pr_r <= 1'b0;
         armed_r <= 1'b0;
      end else begin
         armed_r <= 1'b1; // first edge after release still shows reset outputs
         if (i_wr && i_addr == 16'h7F30) s3_r <= i_wdata;
         if (i_wr && i_addr == 16'h7F1B) dh_r <= i_wdata[3:0];
         if (i_wr && i_addr == 16'h7F3D) fl_r <= i_wdata[5];
         if (i_wr && i_addr == 16'h7F40) pr_r <= i_wdata[0];
      end
   end
   function automatic logic [3:0] bus_mask(input logic [1:0] a);
      return (a == 2'b01) ? 4'h3 : ((a == 2'b10) ? 4'hF : 4'h0);
   endfunction
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_rst);
   sequence rd_sel3;
      i_rd && i_addr == 16'h7F30;
   endsequence
   sequence wr_tach;
      i_wr && i_addr == 16'h7F30 && i_wdata[7];
   endsequence
   //----------------------------------------
   // assertions
   //----------------------------------------
   read_back_a: assert property (rd_sel3 |=> o_rdata == $past(s3_r))
      else $error("select read-back mismatch");
   write_latency_a: assert property (wr_tach ##1 armed_r |=>
      o_fan_speed_in_1 == $past(i_pad_gpio15))
      else $error("select write not applied in time");
   scan_pair_a: assert property (armed_r |-> o_pad_gpio4 ==
      ($past(pr_r) ? $past(i_scan_out_14) : $past(i_gpio4_out)))
      else $error("gpio4 pin source wrong");
   tach_one_a: assert property (armed_r |->
      o_fan_speed_in_1 == ($past(s3_r[7]) & $past(i_pad_gpio15)))
      else $error("first tach routing wrong");
   tach_two_a: assert property (armed_r && !$past(s3_r[5]) |-> !o_fan_speed_in_2)
      else $error("second tach active while unselected");
   general_output_5_pick_a: assert property (armed_r |-> o_pad_general_output_5 == ($past(fl_r) ?
      $past(i_floppy_drive_sel_1_n) :
      ($past(s3_r[6]) ? $past(i_keyboard_reset_out) : $past(i_general_output_5))))
      else $error("output 5 pin source wrong");
   bus_alloc_a: assert property (armed_r |->
      o_bus2_in == ($past(i_pad_bus) | ~bus_mask($past(s3_r[4:3]))))
      else $error("bus pin allocation wrong");
   bus_dir_a: assert property (armed_r |-> o_pad_bus_oe == $past(dh_r))
      else $error("bus pin enable wrong");
   smi_serial_a: assert property (armed_r |->
      o_serial_smi_n == ($past(s3_r[2]) | $past(i_smi_mask) | $past(i_sys_mgmt_irq_n)) &&
      o_slot3_irq2_avail == ($past(s3_r[2]) | $past(i_smi_mask)))
      else $error("serial SMI slot wrong");
   smi_pin_a: assert property (armed_r && $past(s3_r[2]) |-> !o_pad_general_output_7 &&
      o_pad_general_output_7_oe == (!$past(i_sys_mgmt_irq_n) && !$past(i_smi_mask)))
      else $error("open-drain SMI pin wrong");
endmodule
bind pfm3_top pfm3_checker i_pfm3_checker (.*);

// File: verif/test_pfm3_top.sv
// testbench: register calls and pin routing checks for pin function mux bank three
`timescale 1ns/1ps
module test_pfm3_top;
   import pfm3_pkg::*;
   logic i_clock, i_rst = '1, i_wr = '0, i_rd = '0, i_smi_mask = '0, i_gpio4_out = '0;
   logic i_gpio5_out = '0, i_scan_out_14 = '0, i_scan_out_15 = '0, i_scan_out_13 = '0;
   logic i_general_output_5 = '0, i_general_output_6 = '0, i_general_output_7 = '1;
   logic i_keyboard_reset_out = '0, i_floppy_drive_sel_1_n = '0, i_floppy_motor_1_n = '0;
   logic i_sys_mgmt_irq_n = '1, i_general_io_18_out = '0, i_general_io_18_oe = '0;
   logic i_dma_ack_2_n = '0, i_pad_gpio15 = '0, i_pad_gpio16 = '0;
   logic [3:0] i_gpio11_14_out = '0, i_bus2_out = '0, i_pad_bus = '0, m;
   logic [15:0] i_addr = '0;
   logic [7:0] i_wdata = '0, o_rdata;
   logic o_pad_gpio4, o_pad_gpio4_oe, o_pad_gpio5, o_pad_gpio5_oe, o_pad_general_output_5, o_pad_general_output_6;
   logic o_pad_general_output_7, o_pad_general_output_7_oe, o_pad_scan13, o_pad_scan13_oe, o_pad_general_io_18;
   logic o_pad_general_io_18_oe, o_fan_speed_in_1, o_fan_speed_in_2, o_gpio15_in, o_gpio16_in;
   logic o_serial_smi_n, o_slot3_irq2_avail;
   logic [3:0] o_pad_bus, o_pad_bus_oe, o_bus2_in, o_gpio11_14_in;
   logic [7:0] pat[3] = '{8'hFF, 8'hA5, 8'h5A};
   int errors = 0;
   int n_compared = 0;
   int cycles = 0;
   pfm3_top i_pfm3_top (.*);
   //----------------------------------------
   // clock, timeout and access tasks
   //----------------------------------------
   initial begin
      i_clock = 1'b0;
      forever #5 i_clock = ~i_clock;
   end
   // hang guard, well above the roughly 150 cycles the sequence needs
   always @(posedge i_clock) begin
      cycles++;
      if (cycles == 5000) begin
         errors++;
         conclude;
      end
   end
   task automatic conclude;
      if (errors == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge i_clock);
      #1 i_wr = 1'b1;
      i_addr = a;
      i_wdata = d;
      @(posedge i_clock);
      #1 i_wr = 1'b0;
   endtask
   // read data stands one cycle, so it is compared right after the taking edge
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      @(posedge i_clock);
      #1 i_rd = 1'b1;
      i_addr = a;
      @(posedge i_clock);
      #1 i_rd = 1'b0;
      chk(o_rdata, e);
   endtask
   // one registered pin stage after the write's register flop, plus one spare edge
   task automatic settle;
      repeat (2) @(posedge i_clock);
      #1;
   endtask
   //----------------------------------------
   // main sequence
   //----------------------------------------
   initial begin
      repeat (16) @(posedge i_clock);
      #1 i_rst = 1'b0;
      rd(PFM3_ADDR_SEL3, PFM3_RESET_SEL);
      foreach (pat[k]) begin
         wr(PFM3_ADDR_SEL3, pat[k]);
         rd(PFM3_ADDR_SEL3, pat[k]);
      end
      rd(PFM3_ADDR_SEL1, 8'h00);
      rd(16'h1234, 8'h00);
      // scan pair on the gpio4/5 pins, drivers gated by direction bits
      i_scan_out_14 = 1'b1;
      i_gpio5_out = 1'b1;
      wr(PFM3_ADDR_SEL2, 8'h01);
      wr(PFM3_ADDR_DIR_LO, 8'h30);
      settle;
      chk(8'({o_pad_gpio4, o_pad_gpio4_oe, o_pad_gpio5, o_pad_gpio5_oe}), 8'h0D);
      wr(PFM3_ADDR_DIR_LO, 8'h00);
      settle;
      chk(8'({o_pad_gpio4_oe, o_pad_gpio5_oe}), 8'h00);
      wr(PFM3_ADDR_SEL2, 8'h00);
      settle;
      chk(8'({o_pad_gpio4, o_pad_gpio5}), 8'h01);
      // tach inputs; unselected side reads 0
      i_pad_gpio15 = 1'b1;
      i_pad_gpio16 = 1'b1;
      wr(PFM3_ADDR_SEL3, 8'hA0);
      settle;
      chk(8'({o_fan_speed_in_1, o_fan_speed_in_2, o_gpio15_in, o_gpio16_in}), 8'h0C);
      wr(PFM3_ADDR_SEL3, 8'h80);
      settle;
      chk(8'({o_fan_speed_in_1, o_fan_speed_in_2, o_gpio15_in, o_gpio16_in}), 8'h09);
      // only the expected source of each pin is driven high
      for (int k = 0; k < 4; k++) begin
         wr(PFM3_ADDR_SEL1, 8'(k[1]) << PFM3_B_FLOPPY);
         wr(PFM3_ADDR_SEL3, 8'(k[0]) << PFM3_B_KEYBOARD_RESET_OUT);
         i_floppy_drive_sel_1_n = k[1];
         i_keyboard_reset_out = !k[1] && k[0];
         i_general_output_5 = !k[1] && !k[0];
         i_floppy_motor_1_n = k[1];
         i_general_output_6 = !k[1];
         settle;
         chk(8'({o_pad_general_output_5, o_pad_general_output_6}), 8'h03);
      end
      wr(PFM3_ADDR_SEL1, 8'h00);
      // bus allocation codes, all four
      i_pad_bus = 4'hA;
      i_bus2_out = 4'h5;
      i_gpio11_14_out = 4'hC;
      wr(PFM3_ADDR_DIR_HI, 8'h0F);
      for (int k = 0; k < 4; k++) begin
         wr(PFM3_ADDR_SEL3, 8'(k) << PFM3_B_ALLOC_LO);
         m = (k == 1) ? 4'h3 : ((k == 2) ? 4'hF : 4'h0);
         settle;
         chk({o_bus2_in, o_gpio11_14_in}, {4'hA | ~m, 4'hA & ~m});
         chk({o_pad_bus, o_pad_bus_oe}, {(4'h5 & m) | (4'hC & ~m), 4'hF});
      end
      wr(PFM3_ADDR_DIR_HI, 8'h00);
      settle;
      chk(8'(o_pad_bus_oe), 8'h00);
      // SMI path: pin select, mask and SMI level in every combination
      for (int k = 0; k < 8; k++) begin
         wr(PFM3_ADDR_SEL3, 8'(k[2]) << PFM3_B_SMI_PIN);
         i_smi_mask = k[1];
         i_sys_mgmt_irq_n = k[0];
         settle;
         chk(8'({o_serial_smi_n, o_slot3_irq2_avail, o_pad_general_output_7}),
            8'({k[2] | k[1] | k[0], k[2] | k[1], !k[2]}));
         chk(8'(o_pad_general_output_7_oe), 8'(k[2] ? (!k[0] && !k[1]) : 1'b1));
      end
      // scan 13 pin and general_io_18 pin; the reserved bit changes nothing
      i_smi_mask = 1'b0;
      i_general_io_18_out = 1'b1;
      wr(PFM3_ADDR_SEL3, 8'h02);
      settle;
      chk(8'({o_pad_scan13, o_pad_general_io_18, o_pad_scan13_oe, o_pad_general_io_18_oe}), 8'h09);
      wr(PFM3_ADDR_SEL3, 8'h01);
      settle;
      chk(8'({o_pad_scan13, o_pad_general_io_18, o_pad_scan13_oe, o_pad_general_io_18_oe}), 8'h06);
      // second reset in mid-run
      i_rst = 1'b1;
      repeat (2) @(posedge i_clock);
      #1 i_rst = 1'b0;
      rd(PFM3_ADDR_SEL3, PFM3_RESET_SEL);
      conclude;
   end
endmodule
